// [rtl/pseq_top.sv]
// What this block does
// [R1] After supply good: RESET, then low-power
// [R2] Always-on regulator on in RESET, stays on
// [R3] Level mode: key starts power-up after debounce
// [R4] Key level echoed to host output
// [R5] Config read at power-up sets run bit
// [R6] First part releases host core reset
// [R7] Second part starts debounce after core request
// [R8] Supplies enabled in order, 2 ms steps
// [R9] Watchdog starts at power-up completion
// [R10] Software kick moves device to ACTIVE
// [R11] Host pulses keepalive every 2 s, or holds
// [R12] Host clears run bit after echo drops
// [R13] Power-down: assert reset, reverse order, 2 ms
// [R14] Host drops core request on reset
// [R15] Run-bit power-down ends in low-power
// [R16] Watchdog stopped in low-power state
// [R17] Edge mode: held key never wakes
// [R18] Edge mode: rising key edge starts power-up
// [R19] Config read restores level wake mode
// [R20] Only key line starts the system
// [R21] Host core reset driven only by sequencer
// [R22] Watchdog maximum: error, clear run, power-down
// [R23] Level mode: key still high at low-power: power-up again
// [R24] Watchdog error decrements retry; zero freezes
// [R25] Level mode: key de-assert resets retry, clears freeze
// [R26] Debounce length is a cycle count
`timescale 1ns/10ps
`include "pseq_regs.svh"
module pseq_top
	import pseq_pkg::*;
#(
	parameter int NSUP = `PSEQ_NSUP,
	parameter int STEP_CYCLES = `PSEQ_STEP_CYCLES,
	parameter int WD_CYCLES = `PSEQ_WD_CYCLES,
	parameter int DB_CYCLES = `PSEQ_DB_CYCLES,
	parameter pseq_retry_t RETRY_INIT = `PSEQ_RETRY_INIT
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Supply monitor
	input wire logic supply_ok_i,
	// Pins from the host side
	input wire logic key_line_in_i,
	input wire logic core_supply_request_pin_i,
	input wire logic watchdog_keepalive_in_i,
	// Software controls, one-cycle pulses
	input wire logic sw_run_clear_i,
	input wire logic sw_watchdog_keepalive_in_i,
	input wire logic sw_edge_mode_set_i,
	input wire logic sw_wd_error_clear_i,
	// Pins toward the host and supplies
	output logic key_echo_out_o,
	output logic host_core_reset_n_o,
	output logic always_on_regulator_o,
	output logic [NSUP-1:0] supply_en_o,
	// Status
	output pseq_status_s status_o
);

	localparam int CW = `PSEQ_CNT_W;
	localparam int IW = (NSUP > 1) ? $clog2(NSUP) : 1;

	pseq_state_e state_q, state_d;
	logic [CW-1:0] step_cnt_q;
	logic [CW-1:0] wd_cnt_q;
	logic [IW-1:0] idx_q;
	logic [NSUP-1:0] sup_q;
	logic step_tick;
	logic last_idx;
	logic run_q, edge_mode_q, edge_seen_q;
	logic wd_run_q, wd_err_q, freeze_q;
	pseq_retry_t retry_q;
	logic aon_q, host_rst_n_q, echo_q;
	logic keep_prev_q;
	logic key_lvl, key_rise, core_rise;
	logic wake, wd_evt, kick, run_drop;

	// ****************************************
	// Input filters
	// ****************************************
	pseq_debounce #(.CNT_W(CW), .DB_CYCLES(DB_CYCLES)) u_key_db ( // [R26]
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.raw_i(key_line_in_i),
		.level_o(key_lvl),
		.rise_o(key_rise)
	);

	pseq_debounce #(.CNT_W(CW), .DB_CYCLES(DB_CYCLES)) u_core_db ( // [R26]
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.raw_i(core_supply_request_pin_i),
		.level_o(),
		.rise_o(core_rise)
	);

	// Echo follows the raw line; the host filters it itself
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			echo_q <= 1'b0;
		end else begin
			echo_q <= key_line_in_i; // [R4] [R18]
		end
	end

	// ****************************************
	// Wake decision
	// ****************************************
	// Power button and external reset are not wired in: key only
	assign wake = !freeze_q && (edge_mode_q ? edge_seen_q : key_lvl);
	// [R3] [R17] [R20] [R23] [R24]

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			edge_seen_q <= 1'b0;
		end else if (state_q == PSEQ_ST_LOWPWR && edge_mode_q && key_rise) begin
			edge_seen_q <= 1'b1; // [R18]
		end else if (state_q != PSEQ_ST_LOWPWR) begin
			edge_seen_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			edge_mode_q <= 1'b0;
		end else if (state_q == PSEQ_ST_CFG_READ) begin
			edge_mode_q <= 1'b0; // [R19]
		end else if (sw_edge_mode_set_i) begin
			edge_mode_q <= 1'b1; // [R17]
		end
	end

	// ****************************************
	// Step timer
	// ****************************************
	assign step_tick = (step_cnt_q == CW'(STEP_CYCLES - 1));
	assign last_idx = (idx_q == IW'(NSUP - 1));

	// Restarts on every state change so each step is a full 2 ms
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			step_cnt_q <= '0;
		end else if (state_d != state_q || step_tick) begin
			step_cnt_q <= '0;
		end else begin
			step_cnt_q <= step_cnt_q + CW'(1); // [R8] [R13]
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	assign run_drop = !run_q || wd_evt;
	assign kick = sw_watchdog_keepalive_in_i;

	always_comb begin
		state_d = state_q;
		case (state_q)
			PSEQ_ST_RESET: begin
				state_d = PSEQ_ST_LOWPWR; // [R1]
			end
			PSEQ_ST_LOWPWR: begin
				if (wake) begin
					state_d = PSEQ_ST_CFG_READ; // [R3] [R18] [R23]
				end
			end
			PSEQ_ST_CFG_READ: begin
				state_d = PSEQ_ST_PART1; // [R5]
			end
			PSEQ_ST_PART1: begin
				if (!run_q) begin
					state_d = PSEQ_ST_PDOWN;
				end else if (step_tick) begin
					state_d = PSEQ_ST_WAIT_CORE; // [R6]
				end
			end
			PSEQ_ST_WAIT_CORE: begin
				if (!run_q) begin
					state_d = PSEQ_ST_PDOWN;
				end else if (core_rise) begin
					state_d = PSEQ_ST_PART2; // [R7]
				end
			end
			PSEQ_ST_PART2: begin
				if (!run_q) begin
					state_d = PSEQ_ST_PDOWN;
				end else if (step_tick && last_idx) begin
					state_d = PSEQ_ST_WAIT_KICK; // [R8] [R9]
				end
			end
			PSEQ_ST_WAIT_KICK: begin
				if (run_drop) begin
					state_d = PSEQ_ST_PDOWN; // [R12] [R22]
				end else if (kick) begin
					state_d = PSEQ_ST_ACTIVE; // [R10]
				end
			end
			PSEQ_ST_ACTIVE: begin
				if (run_drop) begin
					state_d = PSEQ_ST_PDOWN; // [R12] [R22]
				end
			end
			PSEQ_ST_PDOWN: begin
				if (step_tick && idx_q == '0) begin
					state_d = PSEQ_ST_LOWPWR; // [R15]
				end
			end
			default: begin
				state_d = PSEQ_ST_RESET;
			end
		endcase
		if (!supply_ok_i) begin
			state_d = PSEQ_ST_RESET; // [R1]
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= PSEQ_ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Supply index and enables
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx_q <= '0;
		end else if (state_q == PSEQ_ST_CFG_READ || state_q == PSEQ_ST_RESET) begin
			idx_q <= '0;
		end else if (step_tick && state_q == PSEQ_ST_PART2 && !last_idx) begin
			idx_q <= idx_q + IW'(1); // [R8]
		end else if (step_tick && state_q == PSEQ_ST_PDOWN && idx_q != '0) begin
			idx_q <= idx_q - IW'(1); // [R13]
		end
	end

	// Enable order is the index order; power-down walks it back
	for (genvar i = 0; i < NSUP; i++) begin : g_sup
		always_ff @(posedge ref_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				sup_q[i] <= 1'b0;
			end else if (state_q == PSEQ_ST_RESET) begin
				sup_q[i] <= 1'b0;
			end else if (step_tick && idx_q == IW'(i)) begin
				if (state_q == PSEQ_ST_PART2 && run_q) begin
					sup_q[i] <= 1'b1; // [R8]
				end else if (state_q == PSEQ_ST_PDOWN) begin
					sup_q[i] <= 1'b0; // [R13]
				end
			end
		end
	end

	// ****************************************
	// Always-on regulator and host reset
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aon_q <= 1'b0;
		end else if (state_q == PSEQ_ST_RESET && supply_ok_i) begin
			aon_q <= 1'b1; // [R2]
		end
	end

	// Only the sequencer touches this pin; host drops its request on it
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_rst_n_q <= 1'b0;
		end else if (state_d == PSEQ_ST_PDOWN || state_d == PSEQ_ST_RESET) begin
			host_rst_n_q <= 1'b0; // [R13] [R14] [R21]
		end else if (state_q == PSEQ_ST_PART1 && step_tick) begin
			host_rst_n_q <= 1'b1; // [R6] [R21]
		end
	end

	// ****************************************
	// Run bit
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_q <= 1'b0;
		end else if (state_q == PSEQ_ST_CFG_READ) begin
			run_q <= 1'b1; // [R5]
		end else if (sw_run_clear_i || wd_evt) begin
			run_q <= 1'b0; // [R12] [R22]
		end
	end

	// ****************************************
	// Watchdog
	// ****************************************
	// Error only counts while the host is meant to be running
	assign wd_evt = wd_run_q && (wd_cnt_q == CW'(WD_CYCLES - 1))
		&& (state_q == PSEQ_ST_WAIT_KICK || state_q == PSEQ_ST_ACTIVE);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_run_q <= 1'b0;
		end else if (state_q == PSEQ_ST_LOWPWR || state_q == PSEQ_ST_RESET) begin
			wd_run_q <= 1'b0; // [R16]
		end else if (state_q == PSEQ_ST_PART2 && state_d == PSEQ_ST_WAIT_KICK) begin
			wd_run_q <= 1'b1; // [R9]
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			keep_prev_q <= 1'b0;
		end else begin
			keep_prev_q <= watchdog_keepalive_in_i;
		end
	end

	// A keepalive held high keeps the count at zero, for debug
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_cnt_q <= '0;
		end else if (!wd_run_q || kick || wd_evt) begin
			wd_cnt_q <= '0; // [R16]
		end else if (watchdog_keepalive_in_i && keep_prev_q) begin
			wd_cnt_q <= '0; // [R11]
		end else if (watchdog_keepalive_in_i) begin
			wd_cnt_q <= '0; // [R11]
		end else begin
			wd_cnt_q <= wd_cnt_q + CW'(1); // [R9]
		end
	end

	// Sticky error flag; a new error wins over a clear
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_err_q <= 1'b0;
		end else if (wd_evt) begin
			wd_err_q <= 1'b1; // [R22]
		end else if (sw_wd_error_clear_i) begin
			wd_err_q <= 1'b0;
		end
	end

	// ****************************************
	// Retry count and freeze
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			retry_q <= RETRY_INIT;
		end else if (wd_evt) begin
			if (retry_q != '0) begin
				retry_q <= retry_q - pseq_retry_t'(1); // [R24]
			end
		end else if (!edge_mode_q && !key_lvl) begin
			retry_q <= RETRY_INIT; // [R25]
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			freeze_q <= 1'b0;
		end else if (wd_evt && retry_q <= pseq_retry_t'(1)) begin
			freeze_q <= 1'b1; // [R24]
		end else if (!edge_mode_q && !key_lvl) begin
			freeze_q <= 1'b0; // [R25]
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign key_echo_out_o = echo_q; // [R4]
	assign host_core_reset_n_o = host_rst_n_q; // [R21]
	assign always_on_regulator_o = aon_q;
	assign supply_en_o = sup_q;

	always_comb begin
		status_o.state = state_q;
		status_o.run_bit = run_q;
		status_o.edge_mode = edge_mode_q;
		status_o.wd_running = wd_run_q;
		status_o.wd_error = wd_err_q;
		status_o.freeze = freeze_q;
		status_o.retry = retry_q;
	end

endmodule : pseq_top

// [rtl/pseq_regs.svh]
`ifndef PSEQ_REGS_SVH
`define PSEQ_REGS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define PSEQ_CLK_MHZ 250
`define PSEQ_STEP_TIME_MS 2
`define PSEQ_STEP_CYCLES (`PSEQ_STEP_TIME_MS * 1000 * `PSEQ_CLK_MHZ)
`define PSEQ_WD_TIME_MS 2000
`define PSEQ_WD_CYCLES (`PSEQ_WD_TIME_MS * 1000 * `PSEQ_CLK_MHZ)
`define PSEQ_DB_CYCLES 256

// ****************************************
// Sizes and reset values
// ****************************************
`define PSEQ_NSUP 6
`define PSEQ_RETRY_INIT 4'h3
`define PSEQ_CNT_W 32

`endif

// [rtl/pseq_pkg.sv]
package pseq_pkg;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		PSEQ_ST_RESET,
		PSEQ_ST_LOWPWR,
		PSEQ_ST_CFG_READ,
		PSEQ_ST_PART1,
		PSEQ_ST_WAIT_CORE,
		PSEQ_ST_PART2,
		PSEQ_ST_WAIT_KICK,
		PSEQ_ST_ACTIVE,
		PSEQ_ST_PDOWN
	} pseq_state_e;

	typedef logic [3:0] pseq_retry_t;

	// ****************************************
	// Status bundle
	// ****************************************
	typedef struct packed {
		pseq_state_e state;
		logic run_bit;
		logic edge_mode;
		logic wd_running;
		logic wd_error;
		logic freeze;
		pseq_retry_t retry;
	} pseq_status_s;

endpackage : pseq_pkg

// [rtl/pseq_debounce.sv]
`timescale 1ns/10ps
module pseq_debounce #(
	parameter int CNT_W = 32,
	parameter int DB_CYCLES = 256
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Raw level
	input wire logic raw_i,
	// Filtered level and its rising edge
	output logic level_o,
	output logic rise_o
);

	logic [CNT_W-1:0] cnt_q;
	logic level_q;
	logic done;

	// ****************************************
	// Stability counter
	// ****************************************
	assign done = (cnt_q == CNT_W'(DB_CYCLES - 1));

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= '0;
		end else if (raw_i == level_q || done) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// Any glitch restarts the count, so only a steady level passes
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			level_q <= 1'b0;
		end else if (raw_i != level_q && done) begin
			level_q <= raw_i;
		end
	end

	assign level_o = level_q;
	assign rise_o = (raw_i != level_q) && done && raw_i;

endmodule : pseq_debounce

// [verif/pseq_top_asserts.sv]
`timescale 1ns/10ps
module pseq_top_asserts
	import pseq_pkg::*;
#(
	parameter int NSUP = 6
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Inputs watched
	input wire logic supply_ok_i,
	input wire logic key_line_in_i,
	input wire logic sw_run_clear_i,
	input wire logic sw_watchdog_keepalive_in_i,
	// Outputs watched
	input wire logic key_echo_out_o,
	input wire logic host_core_reset_n_o,
	input wire logic always_on_regulator_o,
	input wire logic [NSUP-1:0] supply_en_o,
	input wire pseq_status_s status_o
);
	pseq_state_e s;
	assign s = status_o.state;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	// ****************************************
	// Sequences
	// ****************************************
	// Supply kept good so a drop to RESET is not mistaken
	sequence s_pdown_end;
		s == PSEQ_ST_PDOWN && supply_ok_i ##1 s != PSEQ_ST_PDOWN;
	endsequence
	sequence s_low_two;
		s == PSEQ_ST_LOWPWR [*2];
	endsequence

	// ****************************************
	// Properties
	// ****************************************
	a_reset_to_low: assert property (s == PSEQ_ST_RESET && supply_ok_i
		|=> s == PSEQ_ST_LOWPWR) else $error("reset exit wrong");
	a_aon_kept: assert property (s != PSEQ_ST_RESET
		|-> always_on_regulator_o) else $error("regulator off");
	a_echo_key: assert property ($changed(key_line_in_i)
		|=> key_echo_out_o == $past(key_line_in_i)) else $error("echo wrong");
	a_cfg_sets_run: assert property (s == PSEQ_ST_CFG_READ && supply_ok_i
		|=> s == PSEQ_ST_PART1 && status_o.run_bit && !status_o.edge_mode)
		else $error("config read wrong");
	a_part1_release: assert property ($rose(host_core_reset_n_o)
		|-> $past(s) == PSEQ_ST_PART1) else $error("reset release wrong");
	a_kick_active: assert property (s == PSEQ_ST_WAIT_KICK && sw_watchdog_keepalive_in_i
		|=> s == PSEQ_ST_ACTIVE) else $error("kick ignored");
	a_run_clear: assert property (s == PSEQ_ST_ACTIVE && sw_run_clear_i
		|=> !status_o.run_bit ##1 s == PSEQ_ST_PDOWN) else $error("no pdown");
	a_pdown_off: assert property (s == PSEQ_ST_PDOWN
		|-> !host_core_reset_n_o ##1 (supply_en_o & ~$past(supply_en_o)) == '0)
		else $error("pdown wrong");
	a_pdown_low: assert property (s_pdown_end
		|-> s == PSEQ_ST_LOWPWR) else $error("pdown exit wrong");
	a_wd_stopped: assert property (s_low_two
		|-> !status_o.wd_running) else $error("watchdog runs");
	a_wd_error: assert property ($rose(status_o.wd_error)
		|-> !status_o.run_bit ##[0:1] s == PSEQ_ST_PDOWN) else $error("wd event");
	a_freeze_hold: assert property (status_o.freeze && s == PSEQ_ST_LOWPWR
		&& supply_ok_i |=> s == PSEQ_ST_LOWPWR) else $error("freeze broken");
endmodule : pseq_top_asserts

bind pseq_top pseq_top_asserts #(.NSUP(NSUP)) u_asserts (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .supply_ok_i(supply_ok_i),
	.key_line_in_i(key_line_in_i), .sw_run_clear_i(sw_run_clear_i),
	.sw_watchdog_keepalive_in_i(sw_watchdog_keepalive_in_i), .key_echo_out_o(key_echo_out_o),
	.host_core_reset_n_o(host_core_reset_n_o),
	.always_on_regulator_o(always_on_regulator_o),
	.supply_en_o(supply_en_o), .status_o(status_o));

// [verif/pseq_host_model.sv]
`timescale 1ns/10ps
module pseq_host_model (
	// Clock and pins
	input wire logic ref_clk_i,
	input wire logic host_core_reset_n_i,
	input wire logic [1:0] delay_i,
	output logic core_request_o
);
	logic [3:0] cnt_q;
	// Request only after release; dropped at once, not on a clock
	always_ff @(posedge ref_clk_i or negedge host_core_reset_n_i) begin
		if (!host_core_reset_n_i) begin
			cnt_q <= 4'h0;
			core_request_o <= 1'b0;
		end else if (cnt_q != {delay_i, 2'h3}) begin
			cnt_q <= cnt_q + 4'h1;
		end else begin
			core_request_o <= 1'b1;
		end
	end
endmodule : pseq_host_model

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
	import pseq_pkg::*;
	localparam int DB = 4;
	localparam int ST = 8;
	localparam int NS = 6;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic key_i = 1'b0;
	logic keep_i = 1'b0;
	logic clr_i = 1'b0;
	logic kick_i = 1'b0;
	logic edge_i = 1'b0;
	logic eclr_i = 1'b0;
	logic sok = 1'b1;
	logic [1:0] dly = 2'h0;
	logic req, echo, hrst_n, aon;
	logic [NS-1:0] sup;
	pseq_status_s st;
	int mismatches = 0;
	int check_count = 0;
	int n;
	logic [31:0] seed = 32'h1a;

	pseq_top #(.STEP_CYCLES(ST), .WD_CYCLES(64), .DB_CYCLES(DB)) dut (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .supply_ok_i(sok),
		.key_line_in_i(key_i), .core_supply_request_pin_i(req),
		.watchdog_keepalive_in_i(keep_i), .sw_run_clear_i(clr_i),
		.sw_watchdog_keepalive_in_i(kick_i), .sw_edge_mode_set_i(edge_i),
		.sw_wd_error_clear_i(eclr_i), .key_echo_out_o(echo),
		.host_core_reset_n_o(hrst_n), .always_on_regulator_o(aon),
		.supply_en_o(sup), .status_o(st));
	pseq_host_model host (.ref_clk_i(ref_clk_i),
		.host_core_reset_n_i(hrst_n), .delay_i(dly), .core_request_o(req));

	initial forever #2 ref_clk_i = ~ref_clk_i;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic tick(int k);
		repeat (k) @(negedge ref_clk_i);
	endtask : tick
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %0h got %0h", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	// Bounded wait; n holds the cycles spent
	task automatic wait_st(pseq_state_e s, int lim);
		n = 0;
		while (st.state !== s) begin
			tick(1);
			n++;
			if (n > lim) begin
				chk("wait", s, st.state);
				end_of_test();
			end
		end
	endtask : wait_st
	task automatic power_up();
		seed = xs(seed);
		dly = seed[1:0];
		wait_st(PSEQ_ST_PART1, 40);
		chk("run", 1, st.run_bit);
		chk("edge", 0, st.edge_mode);
		wait_st(PSEQ_ST_PART2, 200);
		chk("hrst", 1, hrst_n);
		wait_st(PSEQ_ST_WAIT_KICK, 80);
		chk("p2len", NS * ST, n);
		chk("sup", 6'h3f, sup);
		chk("wdrun", 1, st.wd_running);
	endtask : power_up
	task automatic kick();
		kick_i = 1'b1;
		tick(1);
		kick_i = 1'b0;
		chk("act", PSEQ_ST_ACTIVE, st.state);
	endtask : kick

	// Enables must stay a contiguous run from bit 0
	always @(negedge ref_clk_i) begin
		if (resetn_i && ((sup + 6'h1) & sup) !== 6'h0) chk("order", 0, sup);
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		tick(8);
		resetn_i = 1'b1;
		tick(2);
		chk("aon", 1, aon);
		chk("lowpwr", PSEQ_ST_LOWPWR, st.state);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			key_i = 1'b1;
			tick(1 + seed % 3);
			chk("echo", 1, echo);
			key_i = 1'b0;
			tick(DB + 2);
			chk("glitch", PSEQ_ST_LOWPWR, st.state);
		end
		$display("test glitch done");
		key_i = 1'b1;
		wait_st(PSEQ_ST_CFG_READ, 40);
		chk("wake", DB + 1, n);
		power_up();
		kick();
		keep_i = 1'b1;
		tick(100);
		chk("hold", PSEQ_ST_ACTIVE, st.state);
		keep_i = 1'b0;
		$display("test boot done");
		edge_i = 1'b1;
		tick(1);
		edge_i = 1'b0;
		chk("emode", 1, st.edge_mode);
		clr_i = 1'b1;
		tick(1);
		clr_i = 1'b0;
		wait_st(PSEQ_ST_PDOWN, 3);
		chk("hrst_dn", 0, hrst_n);
		wait_st(PSEQ_ST_LOWPWR, 80);
		chk("pdlen", 1, n >= NS * ST && n <= NS * ST + 1);
		tick(20);
		chk("held", PSEQ_ST_LOWPWR, st.state);
		key_i = 1'b0;
		tick(DB + 2);
		chk("echo", 0, echo);
		key_i = 1'b1;
		wait_st(PSEQ_ST_CFG_READ, 40);
		chk("ewake", DB + 1, n);
		power_up();
		kick();
		$display("test edge done");
		for (int i = 0; i < 3; i++) begin
			wait_st(PSEQ_ST_PDOWN, 100);
			chk("err", 1, st.wd_error);
			chk("run0", 0, st.run_bit);
			chk("retry", 2 - i, st.retry);
			wait_st(PSEQ_ST_LOWPWR, 80);
			if (i < 2) power_up();
		end
		chk("frz", 1, st.freeze);
		tick(30);
		chk("stay", PSEQ_ST_LOWPWR, st.state);
		eclr_i = 1'b1;
		tick(1);
		eclr_i = 1'b0;
		chk("errclr", 0, st.wd_error);
		key_i = 1'b0;
		tick(DB + 3);
		chk("reload", 3, st.retry);
		chk("unfrz", 0, st.freeze);
		key_i = 1'b1;
		power_up();
		$display("test watchdog done");
		// Supply loss mid-run drops straight to RESET
		sok = 1'b0;
		tick(1);
		chk("sok_st", PSEQ_ST_RESET, st.state);
		chk("sok_hrst", 0, hrst_n);
		sok = 1'b1;
		tick(1);
		chk("sok_low", PSEQ_ST_LOWPWR, st.state);
		chk("sok_sup", 0, sup);
		chk("sok_aon", 1, aon);
		$display("test supply done");
		end_of_test();
	end
endmodule : tb
